// File: logic/alert_flags_pkg.sv
// constants, types and helpers for the sticky alert flag register
// assumes a 32-bit serial frame: read bit, 7-bit address, 16 data, crc8
//
// Functional notes
// - 16-bit flag register, 0x2E, reset 0x8000, w1c
// - reset flag set after reset, drives alert
// - reset flag has no mask, always alerts
// - calibration upload crc/ecc fault sets bit 14
// - bit 14 clear ignored while memory fault persists
// - serial access before refresh done sets bit 14
// - early-access bit 14 clears on write one
// - bad frame crc sets bit 13
// - frame without exactly 32 clocks sets bit 12
// - converter saturation sets bit 11
// - converter conversion fault sets bit 10
// - 1.8 V regulator low sets bit 9
// - digital supply low sets bit 8
// - positive analog supply low sets bit 7
// - 5 V regulator low sets bit 6
// - negative supply too high sets bit 5
// - die over temperature sets bit 4
`default_nettype none

package alert_flags_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam int          FLAG_W           = 16;
    localparam int          ADDR_W           = 7;
    localparam logic [6:0]  ALERT_FLAGS_ADDR = 7'h2E;
    localparam logic [15:0] ALERT_FLAGS_RST  = 16'h8000;
    // bits 3..0 belong to the per-channel flags, not held here
    localparam logic [15:0] ALERT_FLAGS_IMPL = 16'hFFF0;

    // bit positions
    localparam int RESET_EVENT_BIT   = 15;
    localparam int CAL_MEM_BIT       = 14;
    localparam int FRAME_CRC_BIT     = 13;
    localparam int EDGE_COUNT_BIT    = 12;
    localparam int SATURATION_BIT    = 11;
    localparam int RANGE_BIT         = 10;
    localparam int REG_1V8_BIT       = 9;
    localparam int DIGITAL_SUP_BIT   = 8;
    localparam int POSITIVE_SUP_BIT  = 7;
    localparam int REG_5V_BIT        = 6;
    localparam int NEGATIVE_SUP_BIT  = 5;
    localparam int OVERTEMP_BIT      = 4;

    ////////////////////////////////////////////////////////////////////////
    // serial frame layout
    localparam int          FRAME_BITS  = 32;
    localparam logic [5:0]  FRAME_EDGES = 6'h20;
    localparam logic [5:0]  EDGE_MAX    = 6'h3F;
    localparam int          READ_BIT    = 31;
    localparam int          ADDR_MSB    = 30;
    localparam int          ADDR_LSB    = 24;
    localparam int          DATA_MSB    = 23;
    localparam int          DATA_LSB    = 8;
    localparam int          CRC_MSB     = 7;
    localparam logic [7:0]  CRC_POLY    = 8'h07;
    localparam logic [7:0]  CRC_INIT    = 8'h00;

    typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_e;

    // crc8 over the 24 leading frame bits, msb first
    function automatic logic [7:0] frame_crc(input logic [23:0] body);
        logic [7:0] crc;
        logic       fb;
        crc = CRC_INIT;
        fb  = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            fb  = crc[7] ^ body[i];
            crc = {crc[6:0], 1'b0};
            if (fb)
            begin
                crc = crc ^ CRC_POLY;
            end
        end
        return crc;
    endfunction : frame_crc

endpackage : alert_flags_pkg

`default_nettype wire

// File: logic/bit_sync.sv
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no word coherence is implied
`timescale 1ns/1ns
`default_nettype none

module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output var  logic [W-1:0] sync_o
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    // first stage feeds only the second stage
    always_comb
    begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta   <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta   <= next_meta;
            sync_o <= next_sync;
        end
    end

endmodule : bit_sync

`default_nettype wire

// File: logic/alert_flags.sv
// sticky alert flag register with its serial access port
// assumes monitor levels and serial pins are asynchronous to ref_clk_i;
// calibration and converter events come from logic on ref_clk_i
`timescale 1ns/1ns
`default_nettype none

module alert_flags (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // serial access pins
    input  wire logic sclk_i,
    input  wire logic sync_n_i,
    input  wire logic sdi_i,
    output var  logic sdo_o,
    // alert pin, low while alerting
    output var  logic alert_n_o,
    // calibration memory state, ref_clk_i domain
    input  wire logic cal_refresh_done_i,
    input  wire logic cal_upload_err_i,
    // converter events, ref_clk_i domain
    input  wire logic converter_saturation_fault_i,
    input  wire logic converter_range_fault_i,
    // monitor comparator levels, asynchronous
    input  wire logic analog_reg_1v8_low_i,
    input  wire logic digital_supply_low_i,
    input  wire logic positive_analog_supply_low_i,
    input  wire logic analog_reg_5v_low_i,
    input  wire logic negative_analog_supply_high_i,
    input  wire logic overtemp_i
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    localparam int FB = alert_flags_pkg::FRAME_BITS;
    localparam int FW = alert_flags_pkg::FLAG_W;

    // synchronised pins
    logic       sclk_s;
    logic       sync_n_s;
    logic       sdi_s;
    logic [5:0] mon_s;

    // serial frame state
    alert_flags_pkg::frame_state_e frame_state;
    alert_flags_pkg::frame_state_e next_frame_state;
    logic          sclk_q;
    logic          next_sclk_q;
    logic          sync_n_q;
    logic          next_sync_n_q;
    logic [5:0]    edge_cnt;
    logic [5:0]    next_edge_cnt;
    logic [FB-1:0] rx_shift;
    logic [FB-1:0] next_rx_shift;
    logic [FB-1:0] tx_shift;
    logic [FB-1:0] next_tx_shift;
    logic [FB-1:0] reply;
    logic [FB-1:0] next_reply;

    // decoded frame strobes
    logic          sclk_rise;
    logic          sclk_fall;
    logic          frame_start;
    logic          frame_end;
    logic          early_access;
    logic          count_bad;
    logic          crc_bad;
    logic          frame_ok;
    logic          hits_flags;
    logic          is_read;
    logic [6:0]    rx_addr;
    logic [15:0]   rx_data;
    logic [7:0]    rx_crc;

    // flag register
    logic [FW-1:0] alert_flags;
    logic [FW-1:0] next_alert_flags;
    logic [FW-1:0] flag_set;
    logic [FW-1:0] flag_clr;
    logic          next_alert_n;
    logic          next_sdo;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // serial pins: sclk, sync_n, sdi
    bit_sync #(
        .W (3)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({sclk_i, sync_n_i, sdi_i}),
        .sync_o    ({sclk_s, sync_n_s, sdi_s})
    );

    // analog monitor comparator levels
    bit_sync #(
        .W (6)
    ) u_mon_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({analog_reg_1v8_low_i,
                     digital_supply_low_i,
                     positive_analog_supply_low_i,
                     analog_reg_5v_low_i,
                     negative_analog_supply_high_i,
                     overtemp_i}),
        .sync_o    (mon_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // frame decode, all on synchronised pin copies

    // edges of the link clock and of the frame select
    assign sclk_rise   = sclk_s & ~sclk_q;
    assign sclk_fall   = ~sclk_s & sclk_q;
    assign frame_start = sync_n_q & ~sync_n_s;
    assign frame_end   = (frame_state == alert_flags_pkg::FRAME_SHIFT)
                         & sync_n_s;

    // received fields
    assign is_read = rx_shift[alert_flags_pkg::READ_BIT];
    assign rx_addr = rx_shift[alert_flags_pkg::ADDR_MSB:
                              alert_flags_pkg::ADDR_LSB];
    assign rx_data = rx_shift[alert_flags_pkg::DATA_MSB:
                              alert_flags_pkg::DATA_LSB];
    assign rx_crc  = rx_shift[alert_flags_pkg::CRC_MSB:0];

    assign early_access = frame_end & ~cal_refresh_done_i;

    // edge count check at frame end
    assign count_bad = frame_end & cal_refresh_done_i
                       & (edge_cnt != alert_flags_pkg::FRAME_EDGES);

    assign crc_bad = frame_end & cal_refresh_done_i & ~count_bad
                     & (rx_crc != alert_flags_pkg::frame_crc(
                            rx_shift[FB-1:alert_flags_pkg::DATA_LSB]));

    // a frame that passed every check
    assign frame_ok   = frame_end & cal_refresh_done_i
                        & ~count_bad & ~crc_bad;
    assign hits_flags = rx_addr == alert_flags_pkg::ALERT_FLAGS_ADDR;

    ////////////////////////////////////////////////////////////////////////
    // serial shift group: next values

    always_comb
    begin
        next_sclk_q      = sclk_s;
        next_sync_n_q    = sync_n_s;
        next_frame_state = frame_state;
        next_edge_cnt    = edge_cnt;
        next_rx_shift    = rx_shift;
        next_tx_shift    = tx_shift;
        next_reply       = reply;
        case (frame_state)
            alert_flags_pkg::FRAME_IDLE:
            begin
                if (frame_start)
                begin
                    next_frame_state = alert_flags_pkg::FRAME_SHIFT;
                    next_edge_cnt    = '0;
                    // reply is handed out once
                    next_tx_shift    = reply;
                    next_reply       = '0;
                end
            end
            alert_flags_pkg::FRAME_SHIFT:
            begin
                if (sync_n_s)
                begin
                    next_frame_state = alert_flags_pkg::FRAME_IDLE;
                    next_tx_shift    = '0;
                end
                else
                begin
                    // sample input on rising link clock edge
                    if (sclk_rise)
                    begin
                        next_rx_shift = {rx_shift[FB-2:0], sdi_s};
                        if (edge_cnt != alert_flags_pkg::EDGE_MAX)
                        begin
                            next_edge_cnt = edge_cnt + 6'h01;
                        end
                    end
                    // launch output on falling edge
                    if (sclk_fall)
                    begin
                        next_tx_shift = {tx_shift[FB-2:0], 1'b0};
                    end
                end
            end
            default:
            begin
                next_frame_state = alert_flags_pkg::FRAME_IDLE;
            end
        endcase
        // a good read prepares the next frame's reply
        if (frame_ok && is_read)
        begin
            next_reply[alert_flags_pkg::READ_BIT] = 1'b0;
            next_reply[alert_flags_pkg::ADDR_MSB:
                       alert_flags_pkg::ADDR_LSB] = rx_addr;
            next_reply[alert_flags_pkg::DATA_MSB:
                       alert_flags_pkg::DATA_LSB] =
                hits_flags ? alert_flags : '0;
            next_reply[alert_flags_pkg::CRC_MSB:0] =
                alert_flags_pkg::frame_crc(
                    next_reply[FB-1:alert_flags_pkg::DATA_LSB]);
        end
    end

    // serial shift group: registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            frame_state <= alert_flags_pkg::FRAME_IDLE;
            sclk_q      <= 1'b0;
            sync_n_q    <= 1'b0; // no start until select seen high
            edge_cnt    <= '0;
            rx_shift    <= '0;
            tx_shift    <= '0;
            reply       <= '0;
        end
        else
        begin
            frame_state <= next_frame_state;
            sclk_q      <= next_sclk_q;
            sync_n_q    <= next_sync_n_q;
            edge_cnt    <= next_edge_cnt;
            rx_shift    <= next_rx_shift;
            tx_shift    <= next_tx_shift;
            reply       <= next_reply;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag group: set and clear terms

    always_comb
    begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[alert_flags_pkg::CAL_MEM_BIT] = cal_upload_err_i
                                                 | early_access;
        flag_set[alert_flags_pkg::EDGE_COUNT_BIT] = count_bad;
        flag_set[alert_flags_pkg::FRAME_CRC_BIT] = crc_bad;
        flag_set[alert_flags_pkg::SATURATION_BIT] =
            converter_saturation_fault_i;
        flag_set[alert_flags_pkg::RANGE_BIT] = converter_range_fault_i;
        flag_set[alert_flags_pkg::REG_1V8_BIT] = mon_s[5];
        flag_set[alert_flags_pkg::DIGITAL_SUP_BIT] = mon_s[4];
        flag_set[alert_flags_pkg::POSITIVE_SUP_BIT] = mon_s[3];
        flag_set[alert_flags_pkg::REG_5V_BIT] = mon_s[2];
        flag_set[alert_flags_pkg::NEGATIVE_SUP_BIT] = mon_s[1];
        flag_set[alert_flags_pkg::OVERTEMP_BIT] = mon_s[0];
        if (frame_ok && !is_read && hits_flags)
        begin
            flag_clr = rx_data;
        end
        if (cal_upload_err_i)
        begin
            flag_clr[alert_flags_pkg::CAL_MEM_BIT] = 1'b0;
        end
    end

    // flag group: next value
    always_comb
    begin
        next_alert_flags = ((alert_flags & ~flag_clr) | flag_set)
                           & alert_flags_pkg::ALERT_FLAGS_IMPL;
        next_alert_n = ~next_alert_flags[alert_flags_pkg::RESET_EVENT_BIT];
        next_sdo     = next_tx_shift[FB-1];
    end

    // flag group: registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            // reset flag and alert after reset
            alert_flags <= alert_flags_pkg::ALERT_FLAGS_RST;
            alert_n_o   <= 1'b0;
            sdo_o       <= 1'b0;
        end
        else
        begin
            alert_flags <= next_alert_flags;
            alert_n_o   <= next_alert_n;
            sdo_o       <= next_sdo;
        end
    end

endmodule : alert_flags

`default_nettype wire

// File: test/alert_flags_monitor.sv
// checker for the alert flag register pins
// assumes the serial host keeps 4 ref_clk per sclk half period
`timescale 1ns/1ns
`default_nettype none

module alert_flags_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdo_o,
    input wire logic alert_n_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    ////////////////////////////////////////////////////////////////////////
    // reset and alert pin
    a_reset_alert_low: assert property (
        $rose(rst_n_i) |-> (!alert_n_o && !sdo_o)[*8])
        else $error("alert or sdo not low after reset");
    a_alert_needs_frame: assert property (
        $rose(alert_n_o) |-> sync_n_i && $past(sync_n_i, 2))
        else $error("alert released outside a frame end");
    a_alert_no_refall: assert property (
        !$fell(alert_n_o))
        else $error("alert reasserted without reset");
    a_alert_quiet_idle: assert property (
        sync_n_i[*8] |=> $stable(alert_n_o))
        else $error("alert moved while link idle");

    ////////////////////////////////////////////////////////////////////////
    // serial reply pin
    a_sdo_idle_low: assert property (
        sync_n_i[*8] |-> !sdo_o)
        else $error("sdo high outside a frame");
    a_sdo_sclk_high: assert property (
        (sclk_i && !sync_n_i)[*3] |=> $stable(sdo_o))
        else $error("sdo changed while sclk high");
    a_reply_lead_zero: assert property (
        $fell(sync_n_i) |-> (!sdo_o)[*8])
        else $error("reply lead bit not zero");
    a_sdo_in_frame: assert property (
        $rose(sdo_o) |-> !sync_n_i)
        else $error("sdo rose outside a frame");
endmodule : alert_flags_monitor

bind alert_flags alert_flags_monitor i_alert_flags_monitor (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .sync_n_i(sync_n_i), .sdo_o(sdo_o), .alert_n_o(alert_n_o));

`default_nettype wire

// File: test/serial_host_model.sv
// behavioural serial host: one frame per start rise
// assumes 160 ns sclk, sclk idle low, sdo sampled on sclk rise
`timescale 1ns/1ns
`default_nettype none

module serial_host_model (
    input  wire logic        start_i,
    input  wire logic [31:0] word_i,
    input  wire logic [5:0]  edges_i,
    input  wire logic        sdo_i,
    output var  logic        sclk_o,
    output var  logic        sync_n_o,
    output var  logic        sdi_o,
    output var  logic [31:0] reply_o,
    output var  logic        done_o
);
    initial
    begin
        sclk_o   = 1'b0;
        sync_n_o = 1'b1;
        sdi_o    = 1'b0;
        reply_o  = 32'h0;
        done_o   = 1'b0;
    end

    // frame: msb first, sclk still between frames, sdi flips when idle
    // host sets edge count
    always @(posedge start_i)
    begin
        done_o   = 1'b0;
        sync_n_o = 1'b0;
        #160;
        for (int i = 0; i < edges_i; i++)
        begin
            sdi_o = word_i[5'(31 - i)];
            #80;
            sclk_o  = 1'b1;
            reply_o = {reply_o[30:0], sdo_i};
            #80;
            sclk_o = 1'b0;
        end
        #80;
        sync_n_o = 1'b1;
        sdi_o    = ~sdi_o;
        #160;
        done_o = 1'b1;
    end
endmodule : serial_host_model

`default_nettype wire

// File: test/alert_flags_test.sv
// self-checking bench for the alert flag register
// assumes the host model frames and the design's reply-next-frame read
`timescale 1ns/1ns
`default_nettype none

module alert_flags_test;
    logic        clk, rst_n, start, sdo, alert_n, sclk, sync_n, sdi, done;
    logic        refresh, upload_err;
    logic [7:0]  src;
    logic [31:0] word, reply;
    logic [5:0]  edges;
    int          fail_count, check_count;

    alert_flags i_alert_flags (.ref_clk_i(clk), .rst_n_i(rst_n),
        .sclk_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi), .sdo_o(sdo),
        .alert_n_o(alert_n), .cal_refresh_done_i(refresh),
        .cal_upload_err_i(upload_err),
        .converter_saturation_fault_i(src[7]),
        .converter_range_fault_i(src[6]), .analog_reg_1v8_low_i(src[5]),
        .digital_supply_low_i(src[4]),
        .positive_analog_supply_low_i(src[3]),
        .analog_reg_5v_low_i(src[2]),
        .negative_analog_supply_high_i(src[1]), .overtemp_i(src[0]));

    serial_host_model i_serial_host_model (.start_i(start), .word_i(word),
        .edges_i(edges), .sdo_i(sdo), .sclk_o(sclk), .sync_n_o(sync_n),
        .sdi_o(sdi), .reply_o(reply), .done_o(done));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [31:0] mk(input logic r, input logic [6:0] a,
                                       input logic [15:0] d);
        logic [7:0]  c;
        logic [23:0] b;
        c = 8'h00;
        b = {r, a, d};
        for (int i = 23; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
        end
        return {b, c};
    endfunction : mk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic frame(input logic [31:0] w, input logic [5:0] n);
        int k;
        k = 0;
        @(negedge clk);
        word  = w;
        edges = n;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        while (done !== 1'b1 && k < 4000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 4000)
        begin
            fail_count++;
            print_verdict();
        end
    endtask : frame

    task automatic wr(input logic [15:0] d);
        frame(mk(1'b0, 7'h2E, d), 6'h20);
    endtask : wr

    // read, then a dummy frame that carries the reply back
    task automatic rd(input logic [15:0] exp);
        frame(mk(1'b1, 7'h2E, 16'h0000), 6'h20);
        frame(mk(1'b1, 7'h00, 16'h0000), 6'h20);
        check(reply, mk(1'b0, 7'h2E, exp));
    endtask : rd

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_early();
        wr(16'h8000);
        refresh = 1'b1;
        check(alert_n, 1'b0);
        rd(16'hC000);
        wr(16'h4000);
        rd(16'h8000);
        wr(16'h8000);
        check(alert_n, 1'b1);
        rd(16'h0000);
    endtask : t_early

    task automatic t_sources();
        for (int i = 0; i < 8; i++)
        begin
            src[i] = 1'b1;
            wr(16'hFFF0);
            src[i] = 1'b0;
            rd(16'h0010 << i);
            wr(16'hFFF0);
            rd(16'h0000);
        end
    endtask : t_sources

    task automatic t_faults();
        frame(mk(1'b0, 7'h2E, 16'hFFF0) ^ 32'h1, 6'h20);
        frame(mk(1'b0, 7'h2E, 16'h2000) ^ 32'h1, 6'h20);
        rd(16'h2000);
        wr(16'h2000);
        frame(mk(1'b0, 7'h2E, 16'h1000), 6'h1F);
        frame(mk(1'b0, 7'h2E, 16'h1000), 6'h21);
        frame(mk(1'b0, 7'h2D, 16'hFFFF), 6'h20);
        rd(16'h1000);
        wr(16'h1000);
        rd(16'h0000);
    endtask : t_faults

    task automatic t_upload();
        upload_err = 1'b1;
        repeat (4) @(negedge clk);
        wr(16'h4000);
        upload_err = 1'b0;
        rd(16'h4000);
        do_reset();
        check(alert_n, 1'b0);
        rd(16'h8000);
    endtask : t_upload

    initial
    begin
        rst_n       = 1'b0;
        start       = 1'b0;
        word        = 32'h0;
        edges       = 6'h20;
        refresh     = 1'b0;
        upload_err  = 1'b0;
        src         = 8'h00;
        fail_count  = 0;
        check_count = 0;
        do_reset();
        t_early();
        t_sources();
        t_faults();
        t_upload();
        print_verdict();
    end
endmodule : alert_flags_test

`default_nettype wire
